/* rtl/flash_protect_pkg.sv */
/*
  Constants shared by the flash protection and timing block: register
  offsets, field positions, reset values and operation lengths.
  Assumes a 128 KB flash array behind the block and 32-bit APB data.
*/
package flash_protect_pkg;

  // Array geometry
  localparam int unsigned ADDR_W        = 17;
  localparam int unsigned REGION_LSB    = 11;
  localparam int unsigned REGION_W      = 6;
  localparam int unsigned REGIONS       = 64;
  localparam int unsigned PAGE_LSB      = 10;
  localparam int unsigned PAGE_W        = 7;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_PROG_EN0  = 12'h000;
  localparam logic [11:0] OFF_PROG_EN1  = 12'h004;
  localparam logic [11:0] OFF_READ_EN0  = 12'h008;
  localparam logic [11:0] OFF_READ_EN1  = 12'h00C;
  localparam logic [11:0] OFF_RELOAD    = 12'h010;
  localparam logic [11:0] OFF_CONTROL   = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h018;
  localparam logic [11:0] OFF_STATUS    = 12'h01C;
  localparam logic [11:0] OFF_ADDR      = 12'h020;
  localparam logic [11:0] OFF_DATA      = 12'h024;

  // Control register fields
  localparam int unsigned CTL_WRITE     = 0;
  localparam int unsigned CTL_ERASE     = 1;
  localparam int unsigned CTL_MERASE    = 2;
  localparam int unsigned CTL_COMMIT    = 3;

  // Mask and status fields
  localparam int unsigned MASK_ACCESS   = 0;
  localparam int unsigned STAT_ACCESS   = 0;
  localparam int unsigned STAT_BUSY     = 1;

  // Reset values
  localparam logic [31:0] POLICY_RESET  = 32'hFFFF_FFFF;
  localparam logic [7:0]  RELOAD_RESET  = 8'h31;

  // Operation lengths in microseconds
  localparam logic [15:0] PROG_TIME_US   = 16'h0014;
  localparam logic [15:0] ERASE_TIME_US  = 16'h0064;
  localparam logic [15:0] MERASE_TIME_US = 16'h00C8;

endpackage : flash_protect_pkg

/* rtl/region_policy_lookup.sv */
/*
  Picks the program-enable and read-enable bits of the 2 KB region that
  an address falls in. Purely combinational; assumes the caller holds
  the 64-bit policy vectors and a byte address into the flash array.
*/
`timescale 1ns/1ns
module region_policy_lookup (
  input  wire logic [63:0] prog_enable,
  input  wire logic [63:0] read_enable,
  input  wire logic [16:0] addr,
  output logic             may_program,
  output logic             may_read
);

  logic [5:0] region;

  // Upper address bits name the region, two erase pages each
  assign region      = addr[flash_protect_pkg::REGION_LSB +: flash_protect_pkg::REGION_W];
  assign may_program = prog_enable[region];
  assign may_read    = read_enable[region];

endmodule : region_policy_lookup

/* rtl/flash_op_timer.sv */
/*
  Times a program or erase operation in microseconds, using a cycles
  per microsecond reload value. Assumes start is a one-cycle pulse given
  only while busy is low.
*/
`timescale 1ns/1ns
module flash_op_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [15:0] length_us,
  input  wire logic [7:0]  reload,
  output logic             busy,
  output logic             done
);

  logic [7:0]  cycle_cnt;
  logic [15:0] us_left;
  logic        us_tick;

  assign us_tick = busy && (cycle_cnt == 8'h00);

  // Prescaler reloads with frequency-minus-one, one tick per microsecond
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_cnt <= 8'h00;
    end else if (start || us_tick) begin
      cycle_cnt <= reload;
    end else if (busy) begin
      cycle_cnt <= cycle_cnt - 8'h01;
    end
  end

  // Microsecond countdown; a zero length still takes one tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_left <= 16'h0000;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        us_left <= length_us;
        busy    <= 1'b1;
      end else if (us_tick) begin
        if (us_left <= 16'h0001) begin
          busy    <= 1'b0;
          done    <= 1'b1;
          us_left <= 16'h0000;
        end else begin
          us_left <= us_left - 16'h0001;
        end
      end
    end
  end

endmodule : flash_op_timer

/* rtl/flash_block_protection_ctrl.sv */
/*
  Flash protection and timing control: APB register file, per-region
  program and read policy, access checks for fetch and data reads, and
  sequencing of program, page erase and mass erase requests.
  Assumes the flash array presents the word at array_addr on
  array_old_word, and that nonvolatile policy storage outside the block
  offers its committed values and stores them on nv_commit.
  Assumes pclk runs at the rate held in the reload register; a stale
  value makes operations run long or short, it never refuses them.
  Limitation: mass erase needs every region open for programming.
  Uncommitted policy clears survive presetn and are undone by por_n only.
  Reads and fetches are held off, not faulted, while the array is busy.
*/
// Chosen here: the placing of the registers and register access over APB.
// How it works
// - Erase works on 1 KB pages; the array fills the page with ones.
// - Program writes one 32-bit word, only turning ones into zeros.
// - Policy is held per 2 KB region, two pages sharing two bits.
// - Sixty-four regions use two program and two read enable words.
// - Program enable one allows program and erase; zero blocks them.
// - Read enable zero permits only instruction fetch, not data reads.
// - Both bits zero means execute only.
// - Program one, read zero allows program, erase and fetch, no reads.
// - Program zero, read one means read only.
// - Both bits one means no protection at all.
// - Data read of a read-protected region is blocked with a bus fault.
// - Refused program or erase raises access interrupt only when unmasked.
// - Every policy bit starts at one from the factory.
// - Bits only clear; uncommitted clears revert on power-on reset only.
// - A commit request makes the cleared bits permanent.
// - Operations are timed from the microsecond reload value.
// - Fetches and literal reads stall while an operation runs.
// - Commit bit in the control register triggers the nonvolatile store.
`timescale 1ns/1ns
module flash_block_protection_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Instruction fetch port
  input  wire logic        fetch_valid,
  input  wire logic [16:0] fetch_addr,
  output logic             fetch_stall,
  // Data read port, software and debugger
  input  wire logic        data_read_valid,
  input  wire logic [16:0] data_read_addr,
  output logic             data_read_stall,
  output logic             data_read_fault,
  // Flash array commands
  input  wire logic [31:0] array_old_word,
  output logic [16:0]      array_addr,
  output logic [31:0]      array_new_word,
  output logic             array_program,
  output logic             array_erase_page,
  output logic             array_mass_erase,
  // Nonvolatile policy store
  input  wire logic [63:0] nv_prog_enable,
  input  wire logic [63:0] nv_read_enable,
  output logic             nv_commit,
  output logic [63:0]      nv_prog_value,
  output logic [63:0]      nv_read_value,
  // Access violation interrupt
  output logic             access_irq
);

  logic [63:0] region_program_enable_bits;
  logic [63:0] region_read_enable_bits;
  logic [7:0]  microsecond_cycle_reload;
  logic        access_violation_irq_mask;
  logic        access_raw;
  logic [2:0]  op_pending;
  logic [16:0] target_addr;
  logic [31:0] target_data;
  logic        por_loaded;
  logic        op_busy;
  logic        op_done;
  logic        op_start;
  logic [15:0] op_length;
  logic        target_may_program;
  logic        read_may_read;
  logic        all_regions_open;
  logic        apb_setup;
  logic        apb_write;
  logic        ctl_write;
  logic        start_write;
  logic        start_erase;
  logic        start_merase;
  logic        refuse_op;
  logic        clear_access;
  logic        mapped;
  logic [31:0] next_prdata;
  logic [31:0] flash_control_register;
  logic [31:0] flash_irq_mask_register;

  // Setup phase latches read data, so every access finishes in one
  assign apb_setup = psel && !penable;
  assign apb_write = psel && penable && pwrite;
  assign pready    = 1'b1;

  // Address decode
  always_comb begin
    mapped = 1'b1;
    if (paddr == flash_protect_pkg::OFF_PROG_EN0) begin
      next_prdata = region_program_enable_bits[31:0];
    end else if (paddr == flash_protect_pkg::OFF_PROG_EN1) begin
      next_prdata = region_program_enable_bits[63:32];
    end else if (paddr == flash_protect_pkg::OFF_READ_EN0) begin
      next_prdata = region_read_enable_bits[31:0];
    end else if (paddr == flash_protect_pkg::OFF_READ_EN1) begin
      next_prdata = region_read_enable_bits[63:32];
    end else if (paddr == flash_protect_pkg::OFF_RELOAD) begin
      next_prdata = {24'h00_0000, microsecond_cycle_reload};
    end else if (paddr == flash_protect_pkg::OFF_CONTROL) begin
      next_prdata = flash_control_register;
    end else if (paddr == flash_protect_pkg::OFF_IRQ_MASK) begin
      next_prdata = flash_irq_mask_register;
    end else if (paddr == flash_protect_pkg::OFF_STATUS) begin
      next_prdata = {30'h0000_0000, op_busy, access_raw};
    end else if (paddr == flash_protect_pkg::OFF_ADDR) begin
      next_prdata = {15'h0000, target_addr};
    end else if (paddr == flash_protect_pkg::OFF_DATA) begin
      next_prdata = target_data;
    end else begin
      next_prdata = 32'h0000_0000;
      mapped      = 1'b0;
    end
  end

  // Unmapped offsets answer with an error, reads of them give zero
  assign pslverr = psel && penable && !mapped;

  // Busy bits stay up while the operation runs, software polls them
  always_comb begin
    flash_control_register = 32'h0000_0000;
    flash_control_register[flash_protect_pkg::CTL_WRITE +: 3] = op_pending;
    flash_irq_mask_register = 32'h0000_0000;
    flash_irq_mask_register[flash_protect_pkg::MASK_ACCESS] = access_violation_irq_mask;
  end

  // Registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Reload; reset value suits the fastest clock the part may run at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      microsecond_cycle_reload <= flash_protect_pkg::RELOAD_RESET;
    end else if (apb_write && paddr == flash_protect_pkg::OFF_RELOAD) begin
      microsecond_cycle_reload <= pwdata[7:0];
    end
  end

  // Interrupt mask; masked by default so a refused request stays quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_violation_irq_mask <= 1'b0;
    end else if (apb_write && paddr == flash_protect_pkg::OFF_IRQ_MASK) begin
      access_violation_irq_mask <= pwdata[flash_protect_pkg::MASK_ACCESS];
    end
  end

  // Target address and data are frozen while an operation runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_addr <= 17'h0_0000;
      target_data <= 32'h0000_0000;
    end else if (apb_write && !op_busy) begin
      if (paddr == flash_protect_pkg::OFF_ADDR) begin
        target_addr <= pwdata[16:0];
      end else if (paddr == flash_protect_pkg::OFF_DATA) begin
        target_data <= pwdata;
      end
    end
  end

  // Policy bits live across the system reset, only power-on clears them;
  // right after power-on the committed values are pulled from the store
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      region_program_enable_bits <= {2{flash_protect_pkg::POLICY_RESET}};
      region_read_enable_bits    <= {2{flash_protect_pkg::POLICY_RESET}};
      por_loaded                 <= 1'b0;
    end else if (!por_loaded) begin
      region_program_enable_bits <= nv_prog_enable;
      region_read_enable_bits    <= nv_read_enable;
      por_loaded                 <= 1'b1;
    end else if (apb_write) begin
      // Writes can only clear bits, a one written leaves a bit alone
      if (paddr == flash_protect_pkg::OFF_PROG_EN0) begin
        region_program_enable_bits[31:0]  <= region_program_enable_bits[31:0] & pwdata;
      end else if (paddr == flash_protect_pkg::OFF_PROG_EN1) begin
        region_program_enable_bits[63:32] <= region_program_enable_bits[63:32] & pwdata;
      end else if (paddr == flash_protect_pkg::OFF_READ_EN0) begin
        region_read_enable_bits[31:0]     <= region_read_enable_bits[31:0] & pwdata;
      end else if (paddr == flash_protect_pkg::OFF_READ_EN1) begin
        region_read_enable_bits[63:32]    <= region_read_enable_bits[63:32] & pwdata;
      end
    end
  end

  // Commit hands the present policy to the nonvolatile store
  assign ctl_write = apb_write && paddr == flash_protect_pkg::OFF_CONTROL;

  // Pulse lasts one cycle; the store must take the values at that edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_commit     <= 1'b0;
      nv_prog_value <= {2{flash_protect_pkg::POLICY_RESET}};
      nv_read_value <= {2{flash_protect_pkg::POLICY_RESET}};
    end else begin
      nv_commit <= ctl_write && pwdata[flash_protect_pkg::CTL_COMMIT];
      if (ctl_write && pwdata[flash_protect_pkg::CTL_COMMIT]) begin
        nv_prog_value <= region_program_enable_bits;
        nv_read_value <= region_read_enable_bits;
      end
    end
  end

  // Policy of the target region, checked combinationally
  region_policy_lookup target_lookup (
    .prog_enable (region_program_enable_bits),
    .read_enable (region_read_enable_bits),
    .addr        (target_addr),
    .may_program (target_may_program),
    .may_read    ()
  );

  // Policy of the region a data read falls in
  region_policy_lookup read_lookup (
    .prog_enable (region_program_enable_bits),
    .read_enable (region_read_enable_bits),
    .addr        (data_read_addr),
    .may_program (),
    .may_read    (read_may_read)
  );

  // Mass erase would wipe every region, so one locked region refuses it
  assign all_regions_open = &region_program_enable_bits;

  // Only one request per control write; the lowest bit wins a tie
  assign start_write  = ctl_write && !op_busy && pwdata[flash_protect_pkg::CTL_WRITE];
  assign start_erase  = ctl_write && !op_busy && !pwdata[flash_protect_pkg::CTL_WRITE]
                        && pwdata[flash_protect_pkg::CTL_ERASE];
  assign start_merase = ctl_write && !op_busy && !pwdata[flash_protect_pkg::CTL_WRITE]
                        && !pwdata[flash_protect_pkg::CTL_ERASE]
                        && pwdata[flash_protect_pkg::CTL_MERASE];

  // Program enable alone decides program and erase for all four mixes
  assign refuse_op = ((start_write || start_erase) && !target_may_program)
                     || (start_merase && !all_regions_open);
  assign op_start  = (start_write || start_erase || start_merase) && !refuse_op;

  // Operation length picked at the start
  always_comb begin
    if (start_write) begin
      op_length = flash_protect_pkg::PROG_TIME_US;
    end else if (start_erase) begin
      op_length = flash_protect_pkg::ERASE_TIME_US;
    end else begin
      op_length = flash_protect_pkg::MERASE_TIME_US;
    end
  end

  // Timer starts only from idle; an operation request while busy is dropped
  flash_op_timer op_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (op_start),
    .length_us (op_length),
    .reload    (microsecond_cycle_reload),
    .busy      (op_busy),
    .done      (op_done)
  );

  // Pending operation shows in the control register until done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_pending <= 3'b000;
    end else if (op_start) begin
      op_pending <= {start_merase, start_erase, start_write};
    end else if (op_done) begin
      op_pending <= 3'b000;
    end
  end

  // Array commands: one pulse at the start of the operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      array_program    <= 1'b0;
      array_erase_page <= 1'b0;
      array_mass_erase <= 1'b0;
      array_new_word   <= 32'h0000_0000;
    end else begin
      array_program    <= op_start && start_write;
      array_erase_page <= op_start && start_erase;
      array_mass_erase <= op_start && start_merase;
      if (op_start && start_write) begin
        array_new_word <= array_old_word & target_data;
      end
    end
  end

  // Erase uses only the page part, the low ten bits are ignored
  assign array_addr = target_addr;

  // Sticky access flag: a new violation beats a clear in the same cycle
  assign clear_access = apb_write && paddr == flash_protect_pkg::OFF_STATUS
                        && pwdata[flash_protect_pkg::STAT_ACCESS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_raw <= 1'b0;
    end else if (refuse_op) begin
      access_raw <= 1'b1;
    end else if (clear_access) begin
      access_raw <= 1'b0;
    end
  end

  // Interrupt follows the flag, so clearing the flag drops it too
  assign access_irq = access_raw && access_violation_irq_mask;

  // Fetches are never refused by policy, only held off during an operation
  assign fetch_stall     = fetch_valid && op_busy;
  assign data_read_stall = data_read_valid && op_busy;

  // Read enable clear blocks data reads the same cycle they appear
  assign data_read_fault = data_read_valid && !op_busy && !read_may_read;

endmodule : flash_block_protection_ctrl

/* verification/flash_protect_asserts.sv */
/*
  Checker of the flash protection block, bound to its top module.
  Sees only top-level ports; one clock domain, reset by presetn.
*/
`timescale 1ns/1ns
module flash_protect_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        fetch_valid,
  input wire logic        fetch_stall,
  input wire logic        data_read_valid,
  input wire logic        data_read_stall,
  input wire logic        data_read_fault,
  input wire logic        array_program,
  input wire logic        array_erase_page,
  input wire logic        array_mass_erase,
  input wire logic        nv_commit,
  input wire logic [63:0] nv_prog_value
);
  logic ctl_wr;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control write in the access cycle; pulses may lag it by one or two edges
  assign ctl_wr = psel && penable && pwrite && paddr == flash_protect_pkg::OFF_CONTROL;

  AST_FAULT_CAUSE: assert property (data_read_fault |-> data_read_valid && !data_read_stall)
    else $error("fault without settled data read");
  AST_STALL_PAIR: assert property (
    fetch_valid && data_read_valid |-> fetch_stall == data_read_stall)
    else $error("fetch and data stall disagree");
  AST_STALL_HOLD: assert property (
    $rose(array_program) |-> (!fetch_valid || fetch_stall)[*8])
    else $error("fetch not stalled during program");
  AST_ONE_OP: assert property (
    array_program |-> !array_erase_page && !array_mass_erase)
    else $error("two array commands at once");
  AST_PROG_PULSE: assert property (array_program |=> !array_program)
    else $error("program pulse too long");
  AST_PROG_CAUSE: assert property (
    $rose(array_program) |-> $past(ctl_wr && pwdata[flash_protect_pkg::CTL_WRITE])
      || $past(ctl_wr && pwdata[flash_protect_pkg::CTL_WRITE], 2))
    else $error("program pulse without request");
  AST_COMMIT_CAUSE: assert property (
    nv_commit |-> $past(ctl_wr && pwdata[flash_protect_pkg::CTL_COMMIT])
      || $past(ctl_wr && pwdata[flash_protect_pkg::CTL_COMMIT], 2))
    else $error("commit without request");
  AST_CLEAR_ONLY: assert property (
    nv_commit |-> (nv_prog_value & ~$past(nv_prog_value)) == 64'h0)
    else $error("committed policy bit went back to one");
endmodule : flash_protect_asserts

bind flash_block_protection_ctrl flash_protect_asserts u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .fetch_valid, .fetch_stall,
  .data_read_valid, .data_read_stall, .data_read_fault, .array_program, .array_erase_page,
  .array_mass_erase, .nv_commit, .nv_prog_value
);

/* verification/flash_array_model.sv */
/*
  Flash array and nonvolatile policy store beside the block.
  Toy array of 64 words, all in one page; storage has no reset.
*/
`timescale 1ns/1ns
module flash_array_model (
  input  wire logic        pclk,
  input  wire logic [16:0] array_addr,
  input  wire logic [31:0] array_new_word,
  input  wire logic        array_program,
  input  wire logic        array_erase_page,
  input  wire logic        array_mass_erase,
  input  wire logic        nv_commit,
  input  wire logic [63:0] nv_prog_value,
  input  wire logic [63:0] nv_read_value,
  output logic [31:0]      array_old_word,
  output logic [63:0]      nv_prog_enable,
  output logic [63:0]      nv_read_enable
);
  logic [31:0] mem [64];
  // Factory state: all policy open, array holds a known pattern
  initial begin
    nv_prog_enable = '1;
    nv_read_enable = '1;
    for (int i = 0; i < 64; i++) mem[i] = 32'h5A5A_0000 | 32'(i);
  end
  assign array_old_word = mem[array_addr[7:2]];
  // Program can only clear bits; erase fills with ones
  always @(posedge pclk) begin
    if (array_program) mem[array_addr[7:2]] <= mem[array_addr[7:2]] & array_new_word;
    if (array_erase_page || array_mass_erase) begin
      for (int i = 0; i < 64; i++) mem[i] <= '1;
    end
  end
  // Committed values survive every reset
  always @(posedge pclk) begin
    if (nv_commit) begin
      nv_prog_enable <= nv_prog_value;
      nv_read_enable <= nv_read_value;
    end
  end
endmodule : flash_array_model

/* verification/tb.sv */
/*
  Self-checking bench of the flash protection block over APB.
  Assumes the array model; random values from a 16-bit LFSR.
*/
`timescale 1ns/1ns
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, a); end end
module tb;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, array_old_word, array_new_word, rdat, wdat, pdat;
  logic        fetch_valid, fetch_stall, data_read_valid, data_read_stall, data_read_fault;
  logic [16:0] fetch_addr, data_read_addr, array_addr;
  logic        array_program, array_erase_page, array_mass_erase, nv_commit, access_irq;
  logic [63:0] nv_prog_enable, nv_read_enable, nv_prog_value, nv_read_value, pe, re;
  logic [15:0] seed;
  int          error_cnt, cmp_count, cyc, npg, ner, nme;

  flash_block_protection_ctrl u_dut (.*);
  flash_array_model u_mem (.*);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, ~seed[7:0], seed[15:8]};
  endfunction : rnd

  task automatic results;
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rst(input logic p, input int n);
    presetn <= 1'b0;
    if (p) por_n <= 1'b0;
    repeat (n) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : rst

  task automatic pol;
    logic [127:0] all;
    all = {re, pe};
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      `CHK("policy", all[32*i +: 32], rdat)
    end
  endtask : pol

  // Regions 0..3 become 00, 01, 10, 11; upper word random
  task automatic clr;
    wdat = rnd();
    apb(1'b1, flash_protect_pkg::OFF_PROG_EN0, 32'hFFFF_FFFC);
    apb(1'b1, flash_protect_pkg::OFF_READ_EN0, 32'hFFFF_FFFA);
    apb(1'b1, flash_protect_pkg::OFF_PROG_EN1, wdat);
    apb(1'b1, flash_protect_pkg::OFF_READ_EN1, ~wdat);
    pe = {wdat, 32'hFFFF_FFFC};
    re = {~wdat, 32'hFFFF_FFFA};
  endtask : clr

  task automatic chk_rd(input logic [16:0] a);
    @(posedge pclk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    data_read_valid <= 1'b1;
    data_read_addr <= a;
    @(posedge pclk);
    `CHK("fault", ~re[a[16:11]], data_read_fault)
    `CHK("fetch_stall", 1'b0, fetch_stall)
  endtask : chk_rd

  // Refused operation: flag set, interrupt only when unmasked
  task automatic refuse(input logic [16:0] a, input logic [31:0] c, input logic m);
    apb(1'b1, flash_protect_pkg::OFF_IRQ_MASK, {31'h0, m});
    apb(1'b1, flash_protect_pkg::OFF_ADDR, 32'(a));
    apb(1'b1, flash_protect_pkg::OFF_CONTROL, c);
    apb(1'b0, flash_protect_pkg::OFF_STATUS, 32'h0);
    `CHK("status", 32'h0000_0001, rdat)
    `CHK("irq", m, access_irq)
    apb(1'b1, flash_protect_pkg::OFF_STATUS, 32'h0000_0001);
  endtask : refuse

  // Allowed operation: reads stall meanwhile, length follows reload
  task automatic op(input logic [16:0] a, input logic [31:0] c, input int len);
    int t0;
    apb(1'b1, flash_protect_pkg::OFF_ADDR, 32'(a));
    apb(1'b1, flash_protect_pkg::OFF_CONTROL, c);
    t0 = cyc;
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    data_read_valid <= 1'b1;
    data_read_addr <= 17'h0_1000;
    @(posedge pclk);
    `CHK("stalls", 3'b110, {fetch_stall, data_read_stall, data_read_fault})
    rdat = 32'h0000_0002;
    while (rdat[1] !== 1'b0) apb(1'b0, flash_protect_pkg::OFF_STATUS, 32'h0);
    `CHK("status", 32'h0, rdat)
    `CHK("op_len", 1'b1, cyc - t0 >= len * 20 - 2 && cyc - t0 <= len * 21 + 10)
  endtask : op

  // Cycle count, array command monitor and hang limit
  always @(posedge pclk) begin
    cyc++;
    ner += int'(array_erase_page === 1'b1);
    nme += int'(array_mass_erase === 1'b1);
    if (array_program === 1'b1) begin
      npg++;
      `CHK("new_word", (32'h5A5A_0000 | 32'(array_addr[7:2])) & pdat, array_new_word)
    end
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    {psel, penable, pwrite, fetch_valid, data_read_valid, presetn, por_n} = '0;
    {paddr, pwdata, fetch_addr, data_read_addr} = '0;
    seed = 16'hC682;
    pdat = '0;
    rst(1'b1, 10);
    pe = '1;
    re = '1;
    pol();
    apb(1'b0, flash_protect_pkg::OFF_RELOAD, 32'h0);
    `CHK("reload", 32'h0000_0031, rdat)
    apb(1'b0, 12'h028, 32'h0);
    `CHK("unmapped", 1'b1, rerr)
    clr();
    apb(1'b1, flash_protect_pkg::OFF_PROG_EN0, 32'hFFFF_FFFF);
    pol();
    for (int i = 0; i < 4; i++) chk_rd(17'(i * 2048 + 4));
    repeat (24) begin
      wdat = rnd();
      chk_rd(wdat[16:0]);
    end
    rst(1'b0, 2);
    pol();
    rst(1'b1, 2);
    pe = '1;
    re = '1;
    pol();
    clr();
    refuse(17'h0_0010, 32'h0000_0001, 1'b1);
    refuse(17'h0_0800, 32'h0000_0002, 1'b0);
    refuse(17'h0_1804, 32'h0000_0004, 1'b1);
    apb(1'b1, flash_protect_pkg::OFF_RELOAD, 32'h0000_0013);
    pdat = rnd();
    apb(1'b1, flash_protect_pkg::OFF_DATA, pdat);
    op(17'h0_1804, 32'h0000_0001, 20);
    op(17'h0_1000, 32'h0000_0002, 100);
    `CHK("pulses", 3'b111, {npg == 1, ner == 1, nme == 0})
    apb(1'b1, flash_protect_pkg::OFF_CONTROL, 32'h0000_0008);
    // Store must see the commit pulse before reset cuts it short
    repeat (3) @(posedge pclk);
    rst(1'b1, 2);
    pol();
    results();
  end
endmodule : tb
